/* hdl/mpp_pkg.sv */
// Package with constants for the motor pole polarisation sequencer.
// Notes on behaviour
// - Only manual start begins pole finding.
// - Clearing enable flag leaves calibration; resets disabled.
// - Start begins calibration only while enabled.
// - Method fixed at standard; others refused.
// - Phase codes 0/1/2 give 90/210/330 degrees.
// - Lock current percent 0 to 100, default 50.
// - Ramp time 0.10 to 20.00 s, default 1.00.
// - Ramp current into phase; rotor locks there.
// - Signed offset added to position, wraps.
// - Report corrected angle within -180..+180.
// - Report applied current as read-only value.
// - State code 0 normal, 1 locking.
// - Zero where U crosses rising; clockwise grows.
package mpp_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PHASE = 8'h04;
   localparam logic [7:0] OFS_PCT = 8'h08;
   localparam logic [7:0] OFS_RAMP = 8'h0C;
   localparam logic [7:0] OFS_CORR = 8'h10;
   localparam logic [7:0] OFS_ANGLE = 8'h14;
   localparam logic [7:0] OFS_CUR = 8'h18;
   localparam logic [7:0] OFS_STATE = 8'h1C;
   localparam logic [7:0] OFS_CONT = 8'h20;
   localparam logic [7:0] OFS_METHOD = 8'h24;
   // Control bit positions.
   localparam int BIT_ENABLE = 0;
   localparam int BIT_START = 1;
   // Angles are signed centidegrees; 36000 is one electrical turn.
   localparam logic signed [17:0] ANG_TURN = 18'sd36000;
   localparam logic signed [17:0] ANG_HALF = 18'sd18000;
   localparam logic signed [17:0] ANG_U = 18'sd9000;
   localparam logic signed [17:0] ANG_V = -18'sd15000;
   localparam logic signed [17:0] ANG_W = -18'sd3000;
   // Percent in hundredths, ramp in hundredths of a second.
   localparam logic [15:0] PCT_RST = 16'h1388;
   localparam logic [15:0] PCT_MAX = 16'h2710;
   localparam logic [15:0] RAMP_RST = 16'h0064;
   localparam logic [15:0] RAMP_MIN = 16'h000A;
   localparam logic [15:0] RAMP_MAX = 16'h07D0;
   localparam logic [1:0] PHASE_RST = 2'h0;
   localparam logic [1:0] METHOD_STD = 2'h1;
   localparam logic [15:0] CONT_RST = 16'h01EA;
   // One ramp tick per hundredth of a second at 50 MHz.
   localparam int CLK_HZ = 50_000_000;
   localparam int TICK_US = 10_000;
   localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
   typedef enum logic [1:0] {
      MPP_NORMAL = 2'b01,
      MPP_LOCKING = 2'b10
   } mpp_state_e;
endpackage

/* hdl/mpp_angle.sv */
// Offset adder that wraps the electrical angle into one turn.
`timescale 1ns/100ps
`default_nettype none
module mpp_angle
   import mpp_pkg::*;
(
   input wire logic signed [17:0] raw, // Measured angle, centidegrees.
   input wire logic signed [17:0] corr, // Signed correction.
   output logic signed [17:0] sum // Wrapped corrected angle.
);
   logic signed [18:0] s;
   always_comb begin
      s = 19'(raw) + 19'(corr);
      if (s > 19'(ANG_HALF)) begin
         s = s - 19'(ANG_TURN);
      end else if (s < -19'(ANG_HALF)) begin
         s = s + 19'(ANG_TURN);
      end
      sum = s[17:0];
   end
endmodule
`default_nettype wire

/* hdl/mpp_ramp.sv */
// Linear current ramp from zero to a target over a number of ticks.
`timescale 1ns/100ps
`default_nettype none
module mpp_ramp
   import mpp_pkg::*;
#(
   parameter int TICK = TICK_CYC // Cycles per hundredth of a second.
) (
   input wire logic hclk, // Clock.
   input wire logic hresetn, // Async reset, active low.
   input wire logic run, // Ramp active; low clears output.
   input wire logic [15:0] target, // Final level, same unit as level.
   input wire logic [15:0] ticks, // Ramp length in hundredths of a second.
   output logic [15:0] level // Present level.
);
   logic [31:0] div;
   logic [15:0] cnt;
   logic [31:0] prod;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div <= 32'h0000_0000;
      end else if (!run || div == 32'(TICK - 1)) begin
         div <= 32'h0000_0000;
      end else begin
         div <= div + 32'h0000_0001;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 16'h0000;
      end else if (!run) begin
         cnt <= 16'h0000;
      end else if (div == 32'(TICK - 1) && cnt < ticks) begin
         cnt <= cnt + 16'h0001;
      end
   end
   // Division keeps the slope exact; it is one cycle of logic per update.
   assign prod = 32'(target) * 32'(cnt);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         level <= 16'h0000;
      end else if (!run) begin
         level <= 16'h0000;
      end else begin
         level <= 16'(prod / 32'(ticks));
      end
   end
endmodule
`default_nettype wire

/* hdl/mpp_top.sv */
// Pole polarisation sequencer with an AHB-Lite register slave.
`timescale 1ns/100ps
`default_nettype none
module mpp_top
   import mpp_pkg::*;
#(
   parameter int TICK = TICK_CYC // Cycles per ramp step; shorten in simulation.
) (
   input wire logic hclk, // Clock, 50 MHz.
   input wire logic hresetn, // Async reset, active low.
   input wire logic hsel, // Slave select.
   input wire logic [31:0] haddr, // Byte address.
   input wire logic [1:0] htrans, // Transfer type.
   input wire logic hwrite, // Write when high.
   input wire logic [2:0] hsize, // Transfer size.
   input wire logic [31:0] hwdata, // Write data.
   input wire logic hready, // Bus ready.
   output logic [31:0] hrdata, // Read data.
   output logic hreadyout, // Slave ready.
   output logic hresp, // Always OKAY.
   input wire logic signed [17:0] sensor_angle, // Raw position, centidegrees.
   output logic signed [17:0] rotor_elec_angle, // Corrected angle.
   output logic [1:0] lock_phase, // Phase being locked.
   output logic signed [17:0] lock_angle, // Target angle of the lock.
   output logic [15:0] lock_current, // Current setpoint, centiamps.
   output logic state_locking // High while locking.
);
   logic calib_enable;
   logic calib_start_req;
   logic [1:0] phase_sel;
   logic [15:0] lock_current_pct;
   logic [15:0] lock_current_ramp_time;
   logic signed [17:0] angle_correction;
   logic [15:0] motor_continuous_current;
   mpp_state_e state;
   mpp_state_e next_state;
   logic start_q;
   logic [15:0] target;
   logic [15:0] ramp_level;
   logic signed [17:0] corr_angle;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic [7:0] rd_addr;
   logic rd_pend;
   logic running;

   function automatic logic signed [17:0] phase_angle(input logic [1:0] p);
      case (p)
         2'h1: phase_angle = ANG_V;
         2'h2: phase_angle = ANG_W;
         default: phase_angle = ANG_U;
      endcase
   endfunction

   // Address phase capture; the slave answers with zero wait states.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         wr_addr <= 8'h00;
         rd_addr <= 8'h00;
      end else begin
         wr_pend <= hsel && hready && htrans[1] && hwrite;
         rd_pend <= hsel && hready && htrans[1] && !hwrite;
         wr_addr <= haddr[7:0];
         rd_addr <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         calib_enable <= 1'b0;
         calib_start_req <= 1'b0;
      end else if (wr_pend && wr_addr == OFS_CTRL) begin
         calib_enable <= hwdata[BIT_ENABLE];
         calib_start_req <= hwdata[BIT_START];
      end
   end

   // Out-of-range values are clamped and phase code 3 is ignored, so the ramp never divides by zero.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_sel <= PHASE_RST;
         lock_current_pct <= PCT_RST;
         lock_current_ramp_time <= RAMP_RST;
         angle_correction <= 18'sd0;
         motor_continuous_current <= CONT_RST;
      end else if (wr_pend) begin
         case (wr_addr)
            OFS_PHASE: begin
               if (hwdata[1:0] != 2'h3) begin
                  phase_sel <= hwdata[1:0];
               end
            end
            OFS_PCT: begin
               lock_current_pct <= (hwdata[15:0] > PCT_MAX) ? PCT_MAX : hwdata[15:0];
            end
            OFS_RAMP: begin
               if (hwdata[15:0] < RAMP_MIN) begin
                  lock_current_ramp_time <= RAMP_MIN;
               end else if (hwdata[15:0] > RAMP_MAX) begin
                  lock_current_ramp_time <= RAMP_MAX;
               end else begin
                  lock_current_ramp_time <= hwdata[15:0];
               end
            end
            OFS_CORR: begin
               if ($signed(hwdata[17:0]) > ANG_HALF) begin
                  angle_correction <= ANG_HALF;
               end else if ($signed(hwdata[17:0]) < -ANG_HALF) begin
                  angle_correction <= -ANG_HALF;
               end else begin
                  angle_correction <= $signed(hwdata[17:0]);
               end
            end
            OFS_CONT: begin
               motor_continuous_current <= hwdata[15:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hsel && hready && htrans[1] && !hwrite) begin
         case (haddr[7:0])
            OFS_CTRL: hrdata <= {30'h0, calib_start_req, calib_enable};
            OFS_PHASE: hrdata <= {30'h0, phase_sel};
            OFS_PCT: hrdata <= {16'h0, lock_current_pct};
            OFS_RAMP: hrdata <= {16'h0, lock_current_ramp_time};
            OFS_CORR: hrdata <= 32'(angle_correction);
            OFS_ANGLE: hrdata <= 32'(rotor_elec_angle);
            OFS_CUR: hrdata <= {16'h0, lock_current};
            OFS_STATE: hrdata <= {31'h0, state_locking};
            OFS_CONT: hrdata <= {16'h0, motor_continuous_current};
            OFS_METHOD: hrdata <= {30'h0, METHOD_STD};
            default: hrdata <= 32'h0000_0000;
         endcase
      end else begin
         hrdata <= 32'h0000_0000;
      end
   end

   // A start is a rising edge of the start flag, seen only while enabled.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         start_q <= 1'b0;
      end else begin
         start_q <= calib_start_req;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         MPP_NORMAL: begin
            if (calib_enable && calib_start_req && !start_q) begin
               next_state = MPP_LOCKING;
            end
         end
         MPP_LOCKING: begin
            if (!calib_enable) begin
               next_state = MPP_NORMAL;
            end
         end
         default: next_state = MPP_NORMAL;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= MPP_NORMAL;
      end else begin
         state <= next_state;
      end
   end

   // Target in centiamps: continuous current scaled by percent hundredths.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         target <= 16'h0000;
      end else begin
         target <= 16'((32'(motor_continuous_current) * 32'(lock_current_pct)) / 32'(PCT_MAX));
      end
   end

   assign running = (state == MPP_LOCKING);

   mpp_ramp #(
      .TICK(TICK)
   ) u_ramp (
      .hclk(hclk),
      .hresetn(hresetn),
      .run(running),
      .target(target),
      .ticks(lock_current_ramp_time),
      .level(ramp_level)
   );

   // Sensor angle is taken as zero at the rising U crossing, growing clockwise.
   mpp_angle u_angle (
      .raw(sensor_angle),
      .corr(angle_correction),
      .sum(corr_angle)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rotor_elec_angle <= 18'sd0;
         lock_phase <= PHASE_RST;
         lock_angle <= ANG_U;
         lock_current <= 16'h0000;
         state_locking <= 1'b0;
      end else begin
         rotor_elec_angle <= corr_angle;
         lock_phase <= phase_sel;
         lock_angle <= phase_angle(phase_sel);
         lock_current <= running ? ramp_level : 16'h0000;
         state_locking <= (next_state == MPP_LOCKING);
      end
   end
endmodule
`default_nettype wire

/* verification/mpp_monitor.sv */
// Port-level checks for the pole polarisation sequencer.
`timescale 1ns/100ps
`default_nettype none
module mpp_monitor
   import mpp_pkg::*;
(
   input wire logic hclk, // Clock.
   input wire logic hresetn, // Async reset, active low.
   input wire logic hreadyout, // Slave ready.
   input wire logic hresp, // Slave response.
   input wire logic signed [17:0] rotor_elec_angle, // Corrected angle.
   input wire logic [1:0] lock_phase, // Phase being locked.
   input wire logic signed [17:0] lock_angle, // Lock target angle.
   input wire logic [15:0] lock_current, // Current setpoint.
   input wire logic state_locking // Locking flag.
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   logic signed [17:0] exp_angle;
   always_comb begin
      exp_angle = (lock_phase == 2'h1) ? ANG_V : ((lock_phase == 2'h2) ? ANG_W : ANG_U);
   end
   sequence s_idle;
      !state_locking [*3];
   endsequence
   sequence s_hold;
      state_locking ##1 state_locking;
   endsequence
   property p_ready;
      hreadyout;
   endproperty
   a_ready: assert property (p_ready) else $error("Slave stretched a transfer.");
   property p_okay;
      !hresp;
   endproperty
   a_okay: assert property (p_okay) else $error("Slave gave an error response.");
   property p_phase;
      lock_phase != 2'h3;
   endproperty
   a_phase: assert property (p_phase) else $error("Reserved phase code accepted.");
   property p_angle;
      $stable(lock_phase) |-> lock_angle == exp_angle;
   endproperty
   a_angle: assert property (p_angle) else $error("Lock angle does not fit phase.");
   property p_range;
      rotor_elec_angle >= -ANG_HALF && rotor_elec_angle <= ANG_HALF;
   endproperty
   a_range: assert property (p_range) else $error("Angle outside half a turn.");
   property p_idle;
      s_idle |-> lock_current == 16'h0000;
   endproperty
   a_idle: assert property (p_idle) else $error("Current applied while idle.");
   property p_mono;
      s_hold |-> lock_current >= $past(lock_current);
   endproperty
   a_mono: assert property (p_mono) else $error("Current fell during lock.");
   property p_start;
      $rose(state_locking) |-> lock_current == 16'h0000;
   endproperty
   a_start: assert property (p_start) else $error("Ramp did not start at zero.");
endmodule
bind mpp_top mpp_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
   .hresp(hresp), .rotor_elec_angle(rotor_elec_angle), .lock_phase(lock_phase),
   .lock_angle(lock_angle), .lock_current(lock_current), .state_locking(state_locking));
`default_nettype wire

/* verification/mpp_motor_model.sv */
// Motor with a misaligned position sensor, driven by the lock outputs.
`timescale 1ns/100ps
`default_nettype none
module mpp_motor_model
   import mpp_pkg::*;
#(
   parameter int SKEW = 12000 // Sensor mounting error, centidegrees.
) (
   input wire logic hclk, // Clock.
   input wire logic [15:0] lock_current, // Applied current.
   input wire logic signed [17:0] lock_angle, // Field angle of the lock.
   output logic signed [17:0] sensor_angle // Raw sensor reading.
);
   function automatic int near(input int a);
      return a > 18000 ? a - 36000 : a;
   endfunction
   initial sensor_angle = 18'sh0_0000;
   // The rotor only snaps to the field once current flows; zero current leaves it put.
   always @(posedge hclk) begin
      if (lock_current != 16'h0000) begin
         sensor_angle <= 18'(near(lock_angle + SKEW));
      end
   end
endmodule
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the pole polarisation sequencer.
`timescale 1ns/100ps
`default_nettype none
module tb
   import mpp_pkg::*;
();
   localparam int TICK = 4;
   localparam int SKEW = 12000;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} mpp_row_s;
   localparam mpp_row_s ROWS [17] = '{
      '{1'b0, OFS_CTRL, '0, '0}, '{1'b0, OFS_PHASE, '0, PHASE_RST},
      '{1'b0, OFS_PCT, '0, PCT_RST}, '{1'b0, OFS_RAMP, '0, RAMP_RST},
      '{1'b0, OFS_CORR, '0, '0}, '{1'b0, OFS_STATE, '0, '0}, '{1'b0, OFS_CUR, '0, '0},
      '{1'b0, OFS_CONT, '0, CONT_RST}, '{1'b0, OFS_METHOD, '0, METHOD_STD},
      '{1'b0, 8'h28, '0, '0}, '{1'b1, OFS_METHOD, '0, METHOD_STD},
      '{1'b1, OFS_PHASE, 32'h3, '0}, '{1'b1, OFS_PCT, 32'h0000_4E20, PCT_MAX},
      '{1'b1, OFS_RAMP, 32'h5, RAMP_MIN}, '{1'b1, OFS_RAMP, 32'h0000_0BB8, RAMP_MAX},
      '{1'b1, OFS_CORR, 32'h0000_7530, 32'h0000_4650}, '{1'b1, 8'h28, 32'h0000_FFFF, '0}};
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, state_locking;
   logic [31:0] haddr, hwdata, hrdata, r, exp_cur;
   logic [1:0] htrans, lock_phase;
   logic [2:0] hsize;
   logic signed [17:0] sensor_angle, rotor_elec_angle, lock_angle;
   logic [15:0] lock_current;
   int error_cnt = 0;
   int checks_done = 0;
   int n, p;
   mpp_top #(.TICK(TICK)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sensor_angle(sensor_angle),
      .rotor_elec_angle(rotor_elec_angle), .lock_phase(lock_phase), .lock_angle(lock_angle),
      .lock_current(lock_current), .state_locking(state_locking));
   mpp_motor_model #(.SKEW(SKEW)) u_motor (.hclk(hclk), .lock_current(lock_current),
      .lock_angle(lock_angle), .sensor_angle(sensor_angle));
   function automatic int wrap(input int a);
      return a > 18000 ? a - 36000 : (a < -18000 ? a + 36000 : a);
   endfunction
   task automatic final_report();
      $display("Checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic tmo();
      error_cnt++;
      $display("[ERR] %0t wait ran out", $time);
      final_report();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Waits for the slave's ready at a rising edge, never for a fixed count.
   task automatic hs();
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         tmo();
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      hs();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      hs();
      r = hrdata;
   endtask
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (ROWS[i]) begin
         if (ROWS[i].w) begin
            xfer(1'b1, ROWS[i].a, ROWS[i].d);
         end
         xfer(1'b0, ROWS[i].a, '0);
         chk(r, ROWS[i].e);
      end
      for (p = 0; p < 3; p++) begin
         xfer(1'b1, OFS_PHASE, 32'(p));
         repeat (3) @(posedge hclk);
         chk(32'(lock_phase), 32'(p));
         chk(32'(lock_angle), 32'(wrap(9000 + 12000 * p)));
      end
      xfer(1'b1, OFS_RAMP, 32'h0000_000A);
      xfer(1'b1, OFS_CORR, '0);
      xfer(1'b1, OFS_CTRL, 32'h2);
      repeat (8) @(posedge hclk);
      chk(32'(state_locking), '0);
      xfer(1'b1, OFS_CTRL, 32'h1);
      repeat (8) @(posedge hclk);
      chk(32'(state_locking), '0);
      xfer(1'b1, OFS_CTRL, 32'h3);
      for (n = 0; n < 20 && state_locking !== 1'b1; n++) @(posedge hclk);
      chk(32'(state_locking), 32'h1);
      xfer(1'b0, OFS_STATE, '0);
      chk(r, 32'h1);
      exp_cur = 32'(CONT_RST) * 32'(PCT_MAX) / 32'h0000_2710;
      for (n = 0; n < 400 && lock_current !== exp_cur[15:0]; n++) @(posedge hclk);
      if (n == 400) begin
         tmo();
      end
      chk(32'(n >= 8 * TICK && n <= 12 * TICK), 32'h1);
      xfer(1'b0, OFS_CUR, '0);
      chk(r, exp_cur);
      chk(32'(rotor_elec_angle), 32'(wrap(-3000 + SKEW)));
      xfer(1'b1, OFS_CORR, 32'h0000_2EE0);
      repeat (3) @(posedge hclk);
      chk(32'(rotor_elec_angle), 32'(wrap(9000 + 12000)));
      // The operator trims the offset so the reading lands on the W target.
      xfer(1'b1, OFS_CORR, 32'hFFFF_D120);
      repeat (3) @(posedge hclk);
      chk(32'(rotor_elec_angle), 32'(ANG_W));
      xfer(1'b1, OFS_CTRL, 32'h1);
      repeat (4) @(posedge hclk);
      chk(32'(state_locking), 32'h1);
      xfer(1'b1, OFS_CTRL, '0);
      repeat (3) @(posedge hclk);
      chk(32'(state_locking), '0);
      chk(32'(lock_current), '0);
      // A reset in the middle of a lock must drop the state and the current at once.
      xfer(1'b1, OFS_CTRL, 32'h1);
      xfer(1'b1, OFS_CTRL, 32'h3);
      repeat (12) @(posedge hclk);
      chk(32'(state_locking), 32'h1);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk(32'(state_locking), '0);
      chk(32'(lock_current), '0);
      hresetn <= 1'b1;
      xfer(1'b0, OFS_CTRL, '0);
      chk(r, '0);
      xfer(1'b0, OFS_CORR, '0);
      chk(r, '0);
      final_report();
   end
endmodule
`default_nettype wire
